// >>> tdcoi_host.sv
// host controller that issues opcodes to the converter's command port
// assumes device handshake flags are synchronous and fall within guard time
// What this block does
// [RULE1] pattern readback: two words read, stored word 0 then word 1
// [RULE2] after opcode, move exactly the required word count, waiting on handshake
// [RULE3] set global offset: write coarse 11-bit word then fine 5-bit word
// [RULE4] read global offset: read coarse word then fine word
// [RULE5] set channel adjust: index in low byte, one word, low 8 bits
// [RULE6] read channel adjust: index in low byte, one word read back
// [RULE7] rc adjust opcodes accepted, carry no words
// [RULE8] read chip id: chip index in low nibble, one word read
// [RULE9] firmware revision: one word read, low byte meaningful
// [RULE10] loop reset opcode sent with no words
// [RULE11] scan image parity bit is never set by the host
// [RULE12] scan word write: index up to 0x28, one word written
// [RULE13] scan word read: index in low byte, one word read
// [RULE14] load image to all chips, or single chip by index, no words
// [RULE15] reload default image opcode, no words
// [RULE16] read chip errors: one word read
// [RULE17] read dll lock: one word read
// [RULE18] read chip status: four words read
// [RULE19] eeprom write: address word then data byte word
// [RULE20] eeprom configuration addresses up to 0x28 refused unless allowed
// [RULE21] old firmware: wait over 10 ms after eeprom write
// [RULE22] opcode is one word: command high byte, index low byte
`timescale 1ns/1ps
module tdcoi_host #(
	parameter int unsigned EE_WAIT_CYC = tdcoi_pkg::EE_WAIT_CYC_DEF,
	parameter int unsigned MAX_CHAN = 127,
	parameter int unsigned MAX_CHIP = 3
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// avalon-mm slave
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// device command port
	output logic [15:0] MICRO_WDATA,
	output logic MICRO_WR,
	output logic MICRO_RD,
	input wire logic [15:0] MICRO_RDATA,
	input wire logic MICRO_WR_OK,
	input wire logic MICRO_RD_OK
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	tdcoi_pkg::tdcoi_state_t state;
	tdcoi_pkg::tdcoi_dev_t dev;
	logic [1:0] bus_stage;
	logic [15:0] opcode;
	logic legacy_fw, allow_cfg, sts_done, sts_err_op, sts_err_arg;
	logic [2:0] wr_left, rd_left, guard;
	logic [1:0] widx, ridx;
	logic [15:0] rx_word;
	logic [31:0] ee_cnt;
	logic sent_param;
	logic [15:0] mem_rd;

	// ----------------------------------------------------------------
	// opcode decode
	// ----------------------------------------------------------------
	function automatic tdcoi_pkg::tdcoi_info_t cmd_info(input logic [7:0] c);
		tdcoi_pkg::tdcoi_info_t i;
		i = '{known: 1'b1, nwr: 3'h0, nrd: 3'h0};
		case (c)
			// [RULE1] two pattern words
			tdcoi_pkg::CMD_RD_PAT32: i.nrd = 3'h2;
			// [RULE3] coarse then fine
			tdcoi_pkg::CMD_SET_GOFS: i.nwr = 3'h2;
			// [RULE4] coarse then fine
			tdcoi_pkg::CMD_RD_GOFS: i.nrd = 3'h2;
			// [RULE5] one offset word
			tdcoi_pkg::CMD_SET_CHADJ: i.nwr = 3'h1;
			// [RULE6] one offset word
			tdcoi_pkg::CMD_RD_CHADJ: i.nrd = 3'h1;
			// [RULE7] no function, no words
			tdcoi_pkg::CMD_SET_RC, tdcoi_pkg::CMD_RD_RC, tdcoi_pkg::CMD_SAVE_RC: i.nwr = 3'h0;
			// [RULE8] id word
			tdcoi_pkg::CMD_RD_ID: i.nrd = 3'h1;
			// [RULE9] revision word
			tdcoi_pkg::CMD_RD_FWREV: i.nrd = 3'h1;
			// [RULE10] plain opcode
			tdcoi_pkg::CMD_RST_LOOPS: i.nwr = 3'h0;
			// [RULE12] one image word
			tdcoi_pkg::CMD_SCAN_WR: i.nwr = 3'h1;
			// [RULE13] one image word
			tdcoi_pkg::CMD_SCAN_RD: i.nrd = 3'h1;
			// [RULE14] load all or one
			tdcoi_pkg::CMD_SCAN_LOAD, tdcoi_pkg::CMD_SCAN_LOAD1: i.nwr = 3'h0;
			// [RULE15] default image
			tdcoi_pkg::CMD_SCAN_DEF: i.nwr = 3'h0;
			// [RULE16] error word
			tdcoi_pkg::CMD_RD_ERR: i.nrd = 3'h1;
			// [RULE17] lock word
			tdcoi_pkg::CMD_RD_LOCK: i.nrd = 3'h1;
			// [RULE18] four status words
			tdcoi_pkg::CMD_RD_STAT: i.nrd = 3'h4;
			// [RULE19] address then datum
			tdcoi_pkg::CMD_EE_WR: i.nwr = 3'h2;
			default: i.known = 1'b0;
		endcase
		return i;
	endfunction

	wire [7:0] cmd = opcode[15:8];
	wire [7:0] arg = opcode[7:0];
	wire tdcoi_pkg::tdcoi_info_t info = cmd_info(cmd);
	wire chip_cmd = cmd == tdcoi_pkg::CMD_RD_PAT32 || cmd == tdcoi_pkg::CMD_RD_ID
		|| cmd == tdcoi_pkg::CMD_RD_ERR || cmd == tdcoi_pkg::CMD_RD_LOCK
		|| cmd == tdcoi_pkg::CMD_RD_STAT || cmd == tdcoi_pkg::CMD_SCAN_LOAD1
		|| cmd == tdcoi_pkg::CMD_SET_RC || cmd == tdcoi_pkg::CMD_RD_RC;
	wire chan_cmd = cmd == tdcoi_pkg::CMD_SET_CHADJ || cmd == tdcoi_pkg::CMD_RD_CHADJ;
	wire scan_cmd = cmd == tdcoi_pkg::CMD_SCAN_WR || cmd == tdcoi_pkg::CMD_SCAN_RD;
	// [RULE20] configuration area guarded
	wire ee_cfg_hit = cmd == tdcoi_pkg::CMD_EE_WR && !allow_cfg
		&& mem_rd[8:0] <= tdcoi_pkg::EE_CFG_LAST;
	// [RULE8] chip index in low nibble
	wire chip_bad = chip_cmd && 32'(arg[3:0]) > MAX_CHIP;
	// [RULE12] index range checked
	wire arg_bad = chip_bad || (chan_cmd && 32'(arg) > MAX_CHAN)
		|| (scan_cmd && arg > tdcoi_pkg::SCAN_LAST_WORD) || ee_cfg_hit;

	// ----------------------------------------------------------------
	// parameter word shaping
	// ----------------------------------------------------------------
	logic [15:0] wmask;
	always_comb begin
		wmask = 16'hffff;
		case (cmd)
			// [RULE3] coarse 11 bits, fine 5 bits
			tdcoi_pkg::CMD_SET_GOFS: wmask = widx == 2'h0 ? tdcoi_pkg::MASK_COARSE
				: tdcoi_pkg::MASK_FINE;
			// [RULE5] upper byte ignored
			tdcoi_pkg::CMD_SET_CHADJ: wmask = tdcoi_pkg::MASK_BYTE;
			// [RULE19] 9-bit address, 8-bit datum
			tdcoi_pkg::CMD_EE_WR: wmask = widx == 2'h0 ? tdcoi_pkg::MASK_EE_ADDR
				: tdcoi_pkg::MASK_BYTE;
			// [RULE11] parity left to the device
			tdcoi_pkg::CMD_SCAN_WR: if (arg == tdcoi_pkg::SCAN_LAST_WORD) begin
				wmask[tdcoi_pkg::SCAN_PARITY_BIT] = 1'b0;
			end
			default: wmask = 16'hffff;
		endcase
	end

	// ----------------------------------------------------------------
	// bus slave, answer in the second cycle after the request
	// ----------------------------------------------------------------
	wire busy = state != tdcoi_pkg::ST_IDLE;
	wire [3:0] bus_idx = AVS_ADDRESS[5:2];
	wire bus_is_param = bus_idx[3:2] == tdcoi_pkg::IDX_PARAM_HI;
	wire bus_is_mem = bus_is_param || bus_idx[3:2] == tdcoi_pkg::IDX_RESULT_HI;
	// memory port belongs to the sequencer while busy
	wire bus_start = bus_stage == 2'h0 && (AVS_READ || AVS_WRITE) && !(bus_is_mem && busy);
	wire bus_commit = bus_stage == 2'h2 && AVS_WRITE;
	wire go_acc = bus_commit && bus_idx == tdcoi_pkg::IDX_CTRL
		&& AVS_WRITEDATA[tdcoi_pkg::CTRL_GO] && !busy;
	wire opc_wr = bus_commit && bus_idx == tdcoi_pkg::IDX_OPCODE && !busy;
	wire par_wr = bus_commit && bus_is_param && !busy;
	wire seq_store = state == tdcoi_pkg::ST_STORE;
	wire [2:0] mem_waddr = seq_store ? {1'b1, ridx} : {1'b0, bus_idx[1:0]};
	wire [15:0] mem_wdata = seq_store ? rx_word : AVS_WRITEDATA[15:0];
	wire [2:0] mem_raddr = busy ? {1'b0, widx} : {bus_idx[3], bus_idx[1:0]};
	wire [31:0] status_word = {28'h0, sts_err_arg, sts_err_op, sts_done, busy};
	wire [31:0] rd_mux = bus_idx == tdcoi_pkg::IDX_CTRL ? {29'h0, allow_cfg, legacy_fw, 1'b0}
		: bus_idx == tdcoi_pkg::IDX_OPCODE ? {16'h0, opcode}
		: bus_idx == tdcoi_pkg::IDX_STATUS ? status_word
		: bus_is_mem ? {16'h0, mem_rd} : 32'h0;

	tdcoi_mem #(.W(16), .D(8)) u_mem (
		.clk(CLK),
		.wr_en(seq_store || par_wr),
		.wr_addr(mem_waddr),
		.wr_data(mem_wdata),
		.rd_addr(mem_raddr),
		.rd_data(mem_rd)
	);

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			bus_stage <= 2'h0;
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h0;
		end else begin
			bus_stage <= bus_start ? 2'h1 : bus_stage == 2'h1 ? 2'h2 : 2'h0;
			AVS_WAITREQUEST <= bus_stage != 2'h1;
			if (bus_stage == 2'h1) begin
				AVS_READDATA <= AVS_READ ? rd_mux : 32'h0;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			opcode <= tdcoi_pkg::OPCODE_RST;
			legacy_fw <= 1'b0;
			allow_cfg <= 1'b0;
		end else begin
			if (opc_wr) begin
				opcode <= AVS_WRITEDATA[15:0];
			end
			if (bus_commit && bus_idx == tdcoi_pkg::IDX_CTRL) begin
				legacy_fw <= AVS_WRITEDATA[tdcoi_pkg::CTRL_LEGACY_FW];
				allow_cfg <= AVS_WRITEDATA[tdcoi_pkg::CTRL_ALLOW_CFG];
			end
		end
	end

	// ----------------------------------------------------------------
	// opcode sequencer
	// ----------------------------------------------------------------
	wire hs_wr = guard == 3'h0 && MICRO_WR_OK;
	wire hs_rd = guard == 3'h0 && MICRO_RD_OK;
	// [RULE21] legacy firmware needs the pause
	wire ee_pause = cmd == tdcoi_pkg::CMD_EE_WR && legacy_fw;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state <= tdcoi_pkg::ST_IDLE;
			dev <= '0;
			wr_left <= 3'h0;
			rd_left <= 3'h0;
			guard <= 3'h0;
			widx <= 2'h0;
			ridx <= 2'h0;
			rx_word <= 16'h0;
			ee_cnt <= 32'h0;
			sent_param <= 1'b0;
			sts_done <= 1'b0;
			sts_err_op <= 1'b0;
			sts_err_arg <= 1'b0;
		end else begin
			dev.wr <= 1'b0;
			dev.rd <= 1'b0;
			sent_param <= 1'b0;
			if (guard != 3'h0) begin
				guard <= guard - 3'h1;
			end
			case (state)
				tdcoi_pkg::ST_IDLE: if (go_acc) begin
					state <= tdcoi_pkg::ST_LOAD;
					sts_done <= 1'b0;
					sts_err_op <= 1'b0;
					sts_err_arg <= 1'b0;
					widx <= 2'h0;
					ridx <= 2'h0;
				end
				tdcoi_pkg::ST_LOAD: state <= tdcoi_pkg::ST_DECIDE;
				tdcoi_pkg::ST_DECIDE: begin
					wr_left <= info.nwr;
					rd_left <= info.nrd;
					sts_err_op <= !info.known;
					sts_err_arg <= info.known && arg_bad;
					state <= info.known && !arg_bad ? tdcoi_pkg::ST_SEND_OP
						: tdcoi_pkg::ST_FINISH;
				end
				// [RULE22] opcode word goes first
				tdcoi_pkg::ST_SEND_OP: if (hs_wr) begin
					dev.wr <= 1'b1;
					dev.wdata <= opcode;
					guard <= tdcoi_pkg::HS_GUARD_CYC;
					state <= wr_left != 3'h0 ? tdcoi_pkg::ST_FETCH
						: rd_left != 3'h0 ? tdcoi_pkg::ST_RECV : tdcoi_pkg::ST_POST;
				end
				tdcoi_pkg::ST_FETCH: state <= tdcoi_pkg::ST_SEND_W;
				// [RULE2] one write per handshake
				tdcoi_pkg::ST_SEND_W: if (hs_wr) begin
					dev.wr <= 1'b1;
					dev.wdata <= mem_rd & wmask;
					sent_param <= 1'b1;
					guard <= tdcoi_pkg::HS_GUARD_CYC;
					widx <= widx + 2'h1;
					wr_left <= wr_left - 3'h1;
					state <= wr_left != 3'h1 ? tdcoi_pkg::ST_FETCH
						: rd_left != 3'h0 ? tdcoi_pkg::ST_RECV : tdcoi_pkg::ST_POST;
				end
				// [RULE2] one read per handshake
				tdcoi_pkg::ST_RECV: if (hs_rd) begin
					dev.rd <= 1'b1;
					rx_word <= MICRO_RDATA;
					guard <= tdcoi_pkg::HS_GUARD_CYC;
					state <= tdcoi_pkg::ST_STORE;
				end
				// [RULE1] results kept in arrival order
				tdcoi_pkg::ST_STORE: begin
					ridx <= ridx + 2'h1;
					rd_left <= rd_left - 3'h1;
					state <= rd_left != 3'h1 ? tdcoi_pkg::ST_RECV : tdcoi_pkg::ST_POST;
				end
				tdcoi_pkg::ST_POST: begin
					ee_cnt <= EE_WAIT_CYC;
					state <= ee_pause ? tdcoi_pkg::ST_EEWAIT : tdcoi_pkg::ST_FINISH;
				end
				// [RULE21] hold off further commands
				tdcoi_pkg::ST_EEWAIT: begin
					ee_cnt <= ee_cnt - 32'h1;
					if (ee_cnt <= 32'h1) begin
						state <= tdcoi_pkg::ST_FINISH;
					end
				end
				tdcoi_pkg::ST_FINISH: begin
					sts_done <= 1'b1;
					state <= tdcoi_pkg::ST_IDLE;
				end
				default: state <= tdcoi_pkg::ST_IDLE;
			endcase
		end
	end

	assign MICRO_WR = dev.wr;
	assign MICRO_RD = dev.rd;
	assign MICRO_WDATA = dev.wdata;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	wire ee_active = state == tdcoi_pkg::ST_EEWAIT;

	sequence s_start;
		go_acc ##1 state == tdcoi_pkg::ST_LOAD ##1 state == tdcoi_pkg::ST_DECIDE;
	endsequence

	property p_start;
		@(posedge CLK) disable iff (!RST_B) go_acc |-> s_start;
	endproperty
	a_start: assert property (p_start) else $error("go not followed by decode"); // [RULE22]

	property p_bad_op;
		@(posedge CLK) disable iff (!RST_B) s_start and (go_acc && !info.known)
			|-> ##3 sts_err_op;
	endproperty
	a_bad_op: assert property (p_bad_op) else $error("unknown opcode not flagged"); // [RULE22]

	property p_one_dir;
		@(posedge CLK) disable iff (!RST_B) !(MICRO_WR && MICRO_RD);
	endproperty
	a_one_dir: assert property (p_one_dir) else $error("read and write strobes together"); // [RULE2]

	property p_wr_hs;
		@(posedge CLK) disable iff (!RST_B) MICRO_WR |-> $past(MICRO_WR_OK) ##1 !MICRO_WR;
	endproperty
	a_wr_hs: assert property (p_wr_hs) else $error("write strobe without handshake"); // [RULE2]

	property p_rd_hs;
		@(posedge CLK) disable iff (!RST_B) MICRO_RD |-> $past(MICRO_RD_OK) ##1 !MICRO_RD;
	endproperty
	a_rd_hs: assert property (p_rd_hs) else $error("read strobe without handshake"); // [RULE2]

	property p_chadj_mask;
		@(posedge CLK) disable iff (!RST_B)
			sent_param && cmd == tdcoi_pkg::CMD_SET_CHADJ |-> MICRO_WDATA[15:8] == 8'h00;
	endproperty
	a_chadj_mask: assert property (p_chadj_mask) else $error("offset upper byte sent"); // [RULE5]

	property p_parity;
		@(posedge CLK) disable iff (!RST_B)
			sent_param && cmd == tdcoi_pkg::CMD_SCAN_WR && arg == tdcoi_pkg::SCAN_LAST_WORD
			|-> !MICRO_WDATA[tdcoi_pkg::SCAN_PARITY_BIT];
	endproperty
	a_parity: assert property (p_parity) else $error("host set the parity bit"); // [RULE11]

	property p_ee_wait;
		@(posedge CLK) disable iff (!RST_B) $rose(ee_active) |-> (ee_active && !sts_done)[*8];
	endproperty
	a_ee_wait: assert property (p_ee_wait) else $error("eeprom pause cut short"); // [RULE21]

	property p_ack;
		@(posedge CLK) disable iff (!RST_B) !AVS_WAITREQUEST |-> $past(bus_stage) == 2'h1
			##1 AVS_WAITREQUEST;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer not a single cycle");
endmodule

// >>> tdcoi_pkg.sv
// constants, types and register map of the opcode interpreter host
// assumes a 200 MHz clock and a device that exposes a 16-bit command port
package tdcoi_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned EE_WAIT_MS = 10;
	// "more than" the wait, so one extra cycle
	localparam int unsigned EE_WAIT_CYC_DEF = EE_WAIT_MS * CLK_MHZ * 1000 + 1;
	// cycles a handshake flag needs to fall after a strobe
	localparam logic [2:0] HS_GUARD_CYC = 3'h2;

	// ----------------------------------------------------------------
	// host register map, word index = byte address / 4
	// ----------------------------------------------------------------
	localparam logic [3:0] IDX_CTRL = 4'h0;
	localparam logic [3:0] IDX_OPCODE = 4'h1;
	localparam logic [3:0] IDX_STATUS = 4'h2;
	localparam logic [1:0] IDX_PARAM_HI = 2'h1;
	localparam logic [1:0] IDX_RESULT_HI = 2'h2;
	localparam int CTRL_GO = 0;
	localparam int CTRL_LEGACY_FW = 1;
	localparam int CTRL_ALLOW_CFG = 2;
	localparam int STS_BUSY = 0;
	localparam int STS_DONE = 1;
	localparam int STS_ERR_OP = 2;
	localparam int STS_ERR_ARG = 3;
	localparam logic [15:0] OPCODE_RST = 16'h0000;

	// ----------------------------------------------------------------
	// command codes, high byte of an opcode word
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_RD_PAT32 = 8'h47;
	localparam logic [7:0] CMD_SET_GOFS = 8'h50;
	localparam logic [7:0] CMD_RD_GOFS = 8'h51;
	localparam logic [7:0] CMD_SET_CHADJ = 8'h52;
	localparam logic [7:0] CMD_RD_CHADJ = 8'h53;
	localparam logic [7:0] CMD_SET_RC = 8'h54;
	localparam logic [7:0] CMD_RD_RC = 8'h55;
	localparam logic [7:0] CMD_SAVE_RC = 8'h56;
	localparam logic [7:0] CMD_RD_ID = 8'h60;
	localparam logic [7:0] CMD_RD_FWREV = 8'h61;
	localparam logic [7:0] CMD_RST_LOOPS = 8'h62;
	localparam logic [7:0] CMD_SCAN_WR = 8'h70;
	localparam logic [7:0] CMD_SCAN_RD = 8'h71;
	localparam logic [7:0] CMD_SCAN_LOAD = 8'h72;
	localparam logic [7:0] CMD_SCAN_DEF = 8'h73;
	localparam logic [7:0] CMD_RD_ERR = 8'h74;
	localparam logic [7:0] CMD_RD_LOCK = 8'h75;
	localparam logic [7:0] CMD_RD_STAT = 8'h76;
	localparam logic [7:0] CMD_SCAN_LOAD1 = 8'h77;
	localparam logic [7:0] CMD_EE_WR = 8'hc0;

	// ----------------------------------------------------------------
	// field layouts
	// ----------------------------------------------------------------
	localparam logic [15:0] MASK_COARSE = 16'h07ff;
	localparam logic [15:0] MASK_FINE = 16'h001f;
	localparam logic [15:0] MASK_BYTE = 16'h00ff;
	localparam logic [15:0] MASK_EE_ADDR = 16'h01ff;
	localparam logic [7:0] SCAN_LAST_WORD = 8'h28;
	localparam int SCAN_PARITY_BIT = 6;
	localparam logic [8:0] EE_CFG_LAST = 9'h028;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_LOAD = 4'h1,
		ST_DECIDE = 4'h2,
		ST_SEND_OP = 4'h3,
		ST_FETCH = 4'h4,
		ST_SEND_W = 4'h5,
		ST_RECV = 4'h6,
		ST_STORE = 4'h7,
		ST_POST = 4'h8,
		ST_EEWAIT = 4'h9,
		ST_FINISH = 4'ha
	} tdcoi_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] wdata;
	} tdcoi_dev_t;

	typedef struct packed {
		logic known;
		logic [2:0] nwr;
		logic [2:0] nrd;
	} tdcoi_info_t;

endpackage

// >>> tdcoi_mem.sv
// small word memory for parameter and result words
// assumes one writer and one reader per cycle; read data registered
`timescale 1ns/1ps
module tdcoi_mem #(
	parameter int W = 16,
	parameter int D = 8
) (
	// clock
	input wire logic clk,
	// write port
	input wire logic wr_en,
	input wire logic [$clog2(D)-1:0] wr_addr,
	input wire logic [W-1:0] wr_data,
	// read port
	input wire logic [$clog2(D)-1:0] rd_addr,
	output logic [W-1:0] rd_data
);
	logic [W-1:0] mem [D];

	// no reset: contents are don't-care until written
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// >>> tdcoi_dev_model.sv
// behavioural model of the converter's configuration command port
// assumes the host strobes wr/rd for one cycle after seeing wr_ok/rd_ok
`timescale 1ns/1ps
module tdcoi_dev_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// pacing from the bench
	input wire logic slow,
	// command port
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output logic wr_ok,
	output logic rd_ok
);
	// ----------------------------------------------------------------
	// command handling
	// ----------------------------------------------------------------
	logic [15:0] op, v;
	logic [15:0] gofs[2], chadj[128], scan[41];
	int nw, nr, k, dly;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ok <= 1'b0;
			rd_ok <= 1'b0;
			rdata <= 16'h0;
			nw = 0;
			nr = 0;
			dly = 2;
		end else begin
			// idle read bus toggles so a stale word never passes for data
			if (!rd_ok) rdata <= ~rdata;
			if (wr) begin
				wr_ok <= 1'b0;
				dly = slow ? $urandom_range(6, 1) : 0;
				if (nw == 0) begin
					op = wdata;
					k = 0;
					case (wdata[15:8])
						8'h47, 8'h51: nr = 2;
						8'h50, 8'hc0: nw = 2;
						8'h52, 8'h70: nw = 1;
						8'h53, 8'h60, 8'h61, 8'h71, 8'h74, 8'h75: nr = 1;
						8'h76: nr = 4;
						default: nr = 0;
					endcase
				end else begin
					if (op[15:8] == 8'h50) gofs[k[0]] = wdata;
					if (op[15:8] == 8'h52) chadj[op[6:0]] = wdata & 16'h00ff;
					if (op[15:8] == 8'h70) scan[op[5:0]] = wdata;
					k++;
					nw--;
				end
			end else if (rd) begin
				rd_ok <= 1'b0;
				k++;
				nr--;
				dly = slow ? $urandom_range(6, 1) : 0;
			end else if (dly > 0) begin
				dly--;
			end else if (!wr_ok && !rd_ok) begin
				case (op[15:8])
					8'h51: v = gofs[k[0]];
					8'h53: v = chadj[op[6:0]];
					8'h71: v = scan[op[5:0]];
					default: v = op ^ 16'(16'h1111 * k[15:0]);
				endcase
				if (nr > 0) begin
					rd_ok <= 1'b1;
					rdata <= v;
				end else wr_ok <= 1'b1;
			end
		end
	end
endmodule

// >>> tdc_config_opcode_interpreter_bench.sv
// self-checking bench for the opcode interpreter host
// assumes the device model on the command port; short eeprom wait
`timescale 1ns/1ps
module tdc_config_opcode_interpreter_bench;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	localparam int EEW = 16;
	logic CLK, RST_B, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, slow;
	logic [5:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, ctl, rd;
	logic [15:0] MICRO_WDATA, MICRO_RDATA, op;
	logic MICRO_WR, MICRO_RD, MICRO_WR_OK, MICRO_RD_OK;
	logic [15:0] prm[4], wexp[4], rexp[4], sv[4];
	logic [15:0] wq[$];
	logic [7:0] chipc[8] = '{8'h47, 8'h60, 8'h74, 8'h75, 8'h76, 8'h77, 8'h54, 8'h55};
	int chipn[8] = '{2, 1, 1, 1, 4, 0, 0, 0};
	logic [7:0] plainc[5] = '{8'h56, 8'h61, 8'h62, 8'h72, 8'h73};
	int plainn[5] = '{0, 1, 0, 0, 0};
	logic [7:0] aidx[2][3] = '{'{8'h00, 8'h7f, 8'h28}, '{8'h00, 8'h27, 8'h28}};
	logic [15:0] bad[4] = '{16'h6004, 16'h5280, 16'h7029, 16'h9900};
	logic [3:0] bsts[4] = '{4'ha, 4'ha, 4'ha, 4'h6};
	logic [15:0] eadr[3] = '{16'h0010, 16'h0010, 16'h0e29};
	int fail_count, check_count, cyc, last_wr, done_cyc;

	tdcoi_host #(.EE_WAIT_CYC(EEW)) DUT (.CLK(CLK), .RST_B(RST_B), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.MICRO_WDATA(MICRO_WDATA), .MICRO_WR(MICRO_WR), .MICRO_RD(MICRO_RD),
		.MICRO_RDATA(MICRO_RDATA), .MICRO_WR_OK(MICRO_WR_OK), .MICRO_RD_OK(MICRO_RD_OK));
	tdcoi_dev_model dev (.clk(CLK), .rst_b(RST_B), .slow(slow), .wdata(MICRO_WDATA),
		.wr(MICRO_WR), .rd(MICRO_RD), .rdata(MICRO_RDATA), .wr_ok(MICRO_WR_OK),
		.rd_ok(MICRO_RD_OK));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// one avalon access; an idle cycle first keeps drivers single per step
	task automatic bus(input logic w, input int idx, input logic [31:0] d);
		int n;
		@(posedge CLK);
		AVS_ADDRESS <= 6'(idx * 4);
		AVS_WRITE <= w;
		AVS_READ <= !w;
		AVS_WRITEDATA <= d;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 100);
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		if (AVS_WAITREQUEST !== 1'b0) begin
			fail_count++;
			summarize();
		end
	endtask

	task automatic prep(input logic [15:0] o);
		op = o;
		for (int i = 0; i < 4; i++) begin
			prm[i] = 16'($urandom);
			wexp[i] = prm[i];
			rexp[i] = o ^ 16'(16'h1111 * i);
		end
	endtask

	task automatic cmd(input int nw, input int nr, input logic [3:0] sts);
		int n;
		slow <= 1'($urandom_range(1, 0));
		for (int i = 0; i < 4; i++) bus(1'b1, 4 + i, {16'h0, prm[i]});
		bus(1'b1, 1, {16'h0, op});
		if (sts == 4'h2) begin
			wq.push_back(op);
			for (int i = 0; i < nw; i++) wq.push_back(wexp[i]);
		end
		bus(1'b1, 0, ctl | 32'h1);
		n = 0;
		do begin
			bus(1'b0, 2, 32'h0);
			n++;
		end while (rd[1] !== 1'b1 && n < 300);
		// first poll that sees done bounds the pause from above
		done_cyc = cyc;
		if (n >= 300) begin
			fail_count++;
			summarize();
		end
		chk(rd, {28'h0, sts});
		for (int i = 0; i < nr; i++) begin
			bus(1'b0, 8 + i, 32'h0);
			chk(rd, {16'h0, rexp[i]});
		end
		chk(wq.size(), 32'h0);
	endtask

	// every word on the port must be the oldest one noted
	always @(posedge CLK) begin
		cyc++;
		if (MICRO_WR === 1'b1) begin
			last_wr = cyc;
			if (wq.size() > 0) chk({16'h0, MICRO_WDATA}, {16'h0, wq.pop_front()});
			else chk(32'h1, 32'h0);
		end
	end

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end

	initial begin
		RST_B = 1'b0;
		AVS_ADDRESS = 6'h0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h0;
		slow = 1'b0;
		ctl = 32'h0;
		void'($urandom(32'hd7e2));
		repeat (2) @(posedge CLK);
		RST_B <= 1'b1;
		bus(1'b0, 2, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 0, 32'h6);
		bus(1'b0, 0, 32'h0);
		chk(rd, 32'h6);
		bus(1'b0, 3, 32'h0);
		chk(rd, 32'h0);
		for (int c = 0; c < 4; c++) begin
			foreach (chipc[j]) begin
				prep({chipc[j], 8'(c)});
				cmd(0, chipn[j], 4'h2);
			end
		end
		foreach (plainc[j]) begin
			prep({plainc[j], 8'(j)});
			cmd(0, plainn[j], 4'h2);
		end
		prep(16'h5000 | 16'($urandom_range(255, 0)));
		wexp[0] = prm[0] & 16'h07ff;
		wexp[1] = prm[1] & 16'h001f;
		sv = wexp;
		cmd(2, 0, 4'h2);
		prep(16'h5133);
		rexp[0] = sv[0];
		rexp[1] = sv[1];
		cmd(0, 2, 4'h2);
		for (int m = 0; m < 2; m++) begin
			foreach (aidx[m][j]) begin
				prep({m ? 8'h70 : 8'h52, aidx[m][j]});
				wexp[0] = m ? prm[0] : prm[0] & 16'h00ff;
				if (m && aidx[m][j] == 8'h28) wexp[0][6] = 1'b0;
				sv = wexp;
				cmd(1, 0, 4'h2);
				prep({m ? 8'h71 : 8'h53, aidx[m][j]});
				rexp[0] = sv[0];
				cmd(0, 1, 4'h2);
			end
		end
		foreach (bad[j]) begin
			prep(bad[j]);
			cmd(0, 0, bsts[j]);
		end
		// last pass runs as legacy firmware, so the gap is measured after it
		for (int e = 0; e < 3; e++) begin
			prep(16'hc000);
			prm[0] = eadr[e];
			wexp[0] = prm[0] & 16'h01ff;
			wexp[1] = prm[1] & 16'h00ff;
			ctl = 32'h0;
			ctl[e == 1 ? tdcoi_pkg::CTRL_ALLOW_CFG : tdcoi_pkg::CTRL_LEGACY_FW] = (e > 0);
			cmd(2, 0, e == 0 ? 4'ha : 4'h2);
		end
		chk(32'(done_cyc - last_wr >= EEW), 32'h1);
		summarize();
	end
endmodule
